/* icm_ops.v */
// Purpose: Executes instruction-cache maintenance operations of the core.
// Assumes: Translation and array answers arrive the cycle after a lookup;
//          effective and real addresses are equal for tag compares.
// Notes:   One operation at a time; issue_ready is low while busy.
`timescale 1ns/1ps
`default_nettype none
`include "icm_defs.vh"

module icm_ops
(
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        issue_valid,
	input  wire [31:0] instr_word,
	input  wire [31:0] base_data,
	input  wire [31:0] index_data,
	input  wire        user_mode,
	input  wire        data_reloc,
	input  wire        way_select_bit,
	input  wire        read_select_bit,
	input  wire        tlb_hit,
	input  wire        zone_no_access,
	input  wire        attr_cacheable,
	input  wire [43:0] arr_tags,
	input  wire [1:0]  arr_valid,
	input  wire        arr_lru,
	input  wire [63:0] arr_words,
	input  wire        fill_done,
	output wire        issue_ready,
	output wire        lookup_valid,
	output wire [31:0] lookup_addr,
	output wire [7:0]  arr_index,
	output wire [2:0]  arr_word,
	output reg  [1:0]  arr_inval_way,
	output wire        fill_req,
	output wire [31:0] fill_addr,
	output wire        fill_way,
	output wire        dac_load,
	output wire [31:0] dac_addr,
	output reg         exc_data_storage,
	output reg         exc_data_tlb,
	output reg         exc_program,
	output wire        op_done,
	output wire        rsvd_seen,
	output wire [31:0] icache_debug_readout
);

	////////////////////////////////////////////////////////////////////
	// States and storage.

	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_LOOK  = 6'h02;
	localparam [5:0] ST_CHECK = 6'h04;
	localparam [5:0] ST_FILL  = 6'h08;
	localparam [5:0] ST_WALK  = 6'h10;
	localparam [5:0] ST_DONE  = 6'h20;

	reg  [5:0]  state_reg;
	reg  [5:0]  state_next;
	reg  [31:0] ea_reg;
	reg         is_inval_reg;
	reg         is_touch_reg;
	reg         is_read_reg;
	reg         user_reg;
	reg         reloc_reg;
	reg         way_sel_reg;
	reg         read_sel_reg;
	reg         rsvd_reg;
	reg         fill_way_reg;
	reg         fill_way_next;
	reg  [7:0]  walk_reg;
	reg  [31:0] readout_reg;
	reg  [31:0] readout_next;
	reg         exc_ds_next;
	reg         exc_tlb_next;
	reg         exc_prog_next;
	reg  [1:0]  inval_next;

	wire        dec_inval;
	wire        dec_touch;
	wire        dec_all;
	wire        dec_read;
	wire        dec_rsvd;
	wire [31:0] dec_ea;
	wire [1:0]  way_hit;
	wire        any_hit;
	wire        tlb_fault;
	wire        zone_fault;
	wire [21:0] sel_tag;
	wire [31:0] sel_word;
	wire        sel_valid;
	wire        start;

	////////////////////////////////////////////////////////////////////
	// Decode and address formation.

	// The decoder is shared so every operation forms its address the same.
	icm_decode u_decode
	(
		.instr_word        (instr_word),
		.base_data         (base_data),
		.index_data        (index_data),
		.op_line_inval     (dec_inval),
		.op_line_touch     (dec_touch),
		.op_inval_all      (dec_all),
		.op_debug_read     (dec_read),
		.rsvd_nonzero      (dec_rsvd),
		.effective_address (dec_ea)
	);

	// Unrecognised words are not taken, so they never reach the machine.
	assign start = issue_valid && (state_reg == ST_IDLE)
			&& (dec_inval || dec_touch || dec_all || dec_read);

	////////////////////////////////////////////////////////////////////
	// Per-way hit detection.

	genvar w;
	generate
		for (w = 0; w < 2; w = w + 1)
		begin : g_way
			// A way hits when valid and its stored tag equals the address tag.
			assign way_hit[w] = arr_valid[w]
					&& (arr_tags[w*`ICM_TAG_W +: `ICM_TAG_W]
					== ea_reg[`ICM_TAG_HI:`ICM_TAG_LO]);
		end
	endgenerate

	assign any_hit = |way_hit;

	// Fault conditions as seen by a load of this address.
	assign tlb_fault  = reloc_reg && !tlb_hit;
	assign zone_fault = user_reg && reloc_reg && zone_no_access;

	// Debug read way choice and the selected line's contents.
	assign sel_tag = way_sel_reg
			? arr_tags[2*`ICM_TAG_W-1:`ICM_TAG_W]
			: arr_tags[`ICM_TAG_W-1:0];
	assign sel_word = way_sel_reg ? arr_words[63:32]
			: arr_words[31:0];
	assign sel_valid = way_sel_reg ? arr_valid[1] : arr_valid[0];

	////////////////////////////////////////////////////////////////////
	// Next-state and result logic.

	// All actions but operand capture and the walk count are chosen here; the clocked block stores them.
	always @*
	begin
		state_next    = state_reg;
		readout_next  = readout_reg;
		exc_ds_next   = 1'b0;
		exc_tlb_next  = 1'b0;
		exc_prog_next = 1'b0;
		inval_next    = 2'b00;
		fill_way_next = fill_way_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (start)
				begin
					if ((dec_all || dec_read) && user_mode)
					begin
						exc_prog_next = 1'b1;
						state_next    = ST_DONE;
					end
					else if (dec_all)
					begin
						// Operands and translation are not consulted at all.
						state_next = ST_WALK;
					end
					else
					begin
						state_next = ST_LOOK;
					end
				end
			end
			ST_LOOK:
			begin
				state_next = ST_CHECK;
			end
			ST_CHECK:
			begin
				state_next = ST_DONE;
				if (is_read_reg)
				begin
					if (read_sel_reg)
					begin
						// Reserved positions are forced to zero.
						readout_next = 32'h0000_0000;
						readout_next[`ICM_RD_TAG_HI:`ICM_RD_TAG_LO] =
								sel_tag;
						readout_next[`ICM_RD_VALID_BIT] = sel_valid;
						readout_next[`ICM_RD_LRU_BIT] = arr_lru;
					end
					else
					begin
						readout_next = sel_word;
					end
				end
				else if (is_inval_reg)
				begin
					// Missing translation outranks zone protection.
					if (tlb_fault)
					begin
						exc_tlb_next = 1'b1;
					end
					else if (zone_fault)
					begin
						exc_ds_next = 1'b1;
					end
					else
					begin
						// Cacheability is deliberately not looked at.
						inval_next = way_hit;
					end
				end
				else if (is_touch_reg)
				begin
					// A touch swallows its faults and simply completes.
					if (tlb_fault || zone_fault)
					begin
						state_next = ST_DONE;
					end
					else if (any_hit || !attr_cacheable)
					begin
						state_next = ST_DONE;
					end
					else
					begin
						fill_way_next = arr_lru;
						state_next    = ST_FILL;
					end
				end
			end
			ST_FILL:
			begin
				if (fill_done)
				begin
					state_next = ST_DONE;
				end
			end
			ST_WALK:
			begin
				inval_next = 2'b11;
				if (walk_reg == `ICM_LAST_CLASS)
				begin
					state_next = ST_DONE;
				end
			end
			ST_DONE:
			begin
				state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Registers.

	// Operands are captured at issue; the pipeline may move on meanwhile.
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg        <= ST_IDLE;
			ea_reg           <= 32'h0000_0000;
			is_inval_reg     <= 1'b0;
			is_touch_reg     <= 1'b0;
			is_read_reg      <= 1'b0;
			user_reg         <= 1'b0;
			reloc_reg        <= 1'b0;
			way_sel_reg      <= 1'b0;
			read_sel_reg     <= 1'b0;
			rsvd_reg         <= 1'b0;
			fill_way_reg     <= 1'b0;
			walk_reg         <= 8'h00;
			readout_reg      <= `ICM_READOUT_RESET;
			exc_data_storage <= 1'b0;
			exc_data_tlb     <= 1'b0;
			exc_program      <= 1'b0;
			arr_inval_way    <= 2'b00;
		end
		else
		begin
			state_reg        <= state_next;
			fill_way_reg     <= fill_way_next;
			readout_reg      <= readout_next;
			exc_data_storage <= exc_ds_next;
			exc_data_tlb     <= exc_tlb_next;
			exc_program      <= exc_prog_next;
			arr_inval_way    <= inval_next;
			if (start)
			begin
				ea_reg       <= dec_ea;
				is_inval_reg <= dec_inval;
				is_touch_reg <= dec_touch;
				is_read_reg  <= dec_read;
				user_reg     <= user_mode;
				reloc_reg    <= data_reloc;
				way_sel_reg  <= way_select_bit;
				read_sel_reg <= read_select_bit;
				rsvd_reg     <= dec_rsvd;
				walk_reg     <= 8'h00;
			end
			else if (state_reg == ST_WALK)
			begin
				walk_reg <= walk_reg + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs.

	// The invalidate strobe lags the walk by one cycle, so the index
	// driven to the array is the registered copy of the walk counter.
	reg [7:0] inval_idx_reg;
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			inval_idx_reg <= 8'h00;
		end
		else
		begin
			inval_idx_reg <= (state_reg == ST_WALK) ? walk_reg
					: ea_reg[`ICM_IDX_HI:`ICM_IDX_LO];
		end
	end

	assign issue_ready  = (state_reg == ST_IDLE);
	assign lookup_valid = (state_reg == ST_LOOK);
	assign lookup_addr  = ea_reg;
	// Index comes from address bits 19 to 26 except during strobes.
	assign arr_index = (arr_inval_way != 2'b00) ? inval_idx_reg
			: ea_reg[`ICM_IDX_HI:`ICM_IDX_LO];
	assign arr_word  = ea_reg[`ICM_WORD_HI:`ICM_WORD_LO];

	// Fills are whole lines, so the low offset bits are cleared.
	assign fill_req  = (state_reg == ST_FILL);
	assign fill_addr = {ea_reg[31:`ICM_IDX_LO], `ICM_LINE_LO_ZERO};
	assign fill_way  = fill_way_reg;

	// Both line operations count as loads for the address comparators.
	assign dac_load = lookup_valid
			&& (is_inval_reg || is_touch_reg);
	assign dac_addr = ea_reg;

	assign op_done   = (state_reg == ST_DONE);
	assign rsvd_seen = rsvd_reg;

	// No interlock: a read before the update completes sees the old value.
	assign icache_debug_readout = readout_reg;

endmodule

`default_nettype wire

/* icm_defs.vh */
// Purpose: Shared constants for the instruction-cache maintenance block.
// Assumes: Instruction bits are numbered 31 (msb) down to 0 here, so the
//          big-endian bit n of a word sits at little-endian bit 31-n.
// Notes:   Definitions only; included by both design files.
`ifndef ICM_DEFS_VH
`define ICM_DEFS_VH

// Instruction fields.
`define ICM_OPC_HI          31
`define ICM_OPC_LO          26
`define ICM_RSV_HI          25
`define ICM_RSV_LO          21
`define ICM_BASE_HI         20
`define ICM_BASE_LO         16
`define ICM_XO_HI           10
`define ICM_XO_LO           1
`define ICM_RSV_BIT0        0

// Opcode values.
`define ICM_OPC_PRIMARY     6'h1f
`define ICM_XO_LINE_TOUCH   10'h106
`define ICM_XO_INVAL_ALL    10'h3c6
`define ICM_XO_DEBUG_READ   10'h3e6
`define ICM_XO_LINE_INVAL   10'h3d6
`define ICM_BASE_ZERO       5'h00

// Effective address slices: class index, word in line, tag.
`define ICM_IDX_HI          12
`define ICM_IDX_LO          5
`define ICM_WORD_HI         4
`define ICM_WORD_LO         2
`define ICM_TAG_HI          31
`define ICM_TAG_LO          10
`define ICM_TAG_W           22
`define ICM_LINE_LO_ZERO    5'h00
`define ICM_LAST_CLASS      8'hff

// Tag-mode readout layout.
`define ICM_RD_TAG_HI       31
`define ICM_RD_TAG_LO       10
`define ICM_RD_VALID_BIT    4
`define ICM_RD_LRU_BIT      0
`define ICM_READOUT_RESET   32'h0000_0000

`endif

/* icm_decode.v */
// Purpose: Decodes the cache maintenance opcodes and forms the address.
// Assumes: Register contents arrive with the instruction word.
// Notes:   Purely combinational; the main block registers the results.
`timescale 1ns/1ps
`default_nettype none
`include "icm_defs.vh"

module icm_decode
(
	input  wire [31:0] instr_word,
	input  wire [31:0] base_data,
	input  wire [31:0] index_data,
	output wire        op_line_inval,
	output wire        op_line_touch,
	output wire        op_inval_all,
	output wire        op_debug_read,
	output wire        rsvd_nonzero,
	output wire [31:0] effective_address
);

	wire        primary_hit;
	wire [9:0]  ext_code;
	wire [4:0]  base_reg_field;
	wire [31:0] base_value;

	// Only primary opcode 31 carries these operations.
	assign primary_hit = (instr_word[`ICM_OPC_HI:`ICM_OPC_LO]
			== `ICM_OPC_PRIMARY);
	assign ext_code = instr_word[`ICM_XO_HI:`ICM_XO_LO];

	// Extended opcode selects the operation.
	assign op_line_touch = primary_hit
			&& (ext_code == `ICM_XO_LINE_TOUCH);
	assign op_inval_all  = primary_hit
			&& (ext_code == `ICM_XO_INVAL_ALL);
	assign op_debug_read = primary_hit
			&& (ext_code == `ICM_XO_DEBUG_READ);
	assign op_line_inval = primary_hit
			&& (ext_code == `ICM_XO_LINE_INVAL);

	// Flagged for observation only; it never turns into an exception.
	assign rsvd_nonzero = (instr_word[`ICM_RSV_HI:`ICM_RSV_LO] != 5'h00)
			|| instr_word[`ICM_RSV_BIT0];

	// A base field of zero means a literal zero, not register zero.
	assign base_reg_field = instr_word[`ICM_BASE_HI:`ICM_BASE_LO];
	assign base_value = (base_reg_field == `ICM_BASE_ZERO)
			? 32'h0000_0000 : base_data;
	assign effective_address = base_value + index_data;

endmodule

`default_nettype wire

/* icm_ops_monitor.sv */
// Purpose: Concurrent checks on the ports of icm_ops.
// Assumes: One clock domain; config inputs held steady during an op.
// Notes:   Bound to icm_ops from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "icm_defs.vh"

module icm_ops_monitor
(
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        issue_valid,
	input wire logic [31:0] instr_word,
	input wire logic        user_mode,
	input wire logic        read_select_bit,
	input wire logic        fill_done,
	input wire logic        issue_ready,
	input wire logic        lookup_valid,
	input wire logic [31:0] lookup_addr,
	input wire logic        fill_req,
	input wire logic [31:0] fill_addr,
	input wire logic        dac_load,
	input wire logic [31:0] dac_addr,
	input wire logic        exc_data_storage,
	input wire logic        exc_data_tlb,
	input wire logic        exc_program,
	input wire logic        op_done,
	input wire logic [31:0] icache_debug_readout
);
	wire [9:0] xo = instr_word[`ICM_XO_HI:`ICM_XO_LO];
	wire take = issue_valid && issue_ready
		&& instr_word[31:26] == `ICM_OPC_PRIMARY
		&& (xo == `ICM_XO_LINE_TOUCH || xo == `ICM_XO_INVAL_ALL
		|| xo == `ICM_XO_DEBUG_READ || xo == `ICM_XO_LINE_INVAL);
	wire priv = xo == `ICM_XO_INVAL_ALL || xo == `ICM_XO_DEBUG_READ;
	logic [9:0] op_reg;
	//////////////////////////////////////////////////////////////////////
	// Faults are judged against the op in flight, not the next offer.
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			op_reg <= 10'h000;
		else if (take)
			op_reg <= xo;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	//////////////////////////////////////////////////////////////////////
	take_busy_a: assert property (
		take |=> !issue_ready)
		else $error("ready high after take");
	read_time_a: assert property (
		take && xo == `ICM_XO_DEBUG_READ && !user_mode |-> ##3 op_done)
		else $error("debug read late");
	whole_time_a: assert property (
		take && xo == `ICM_XO_INVAL_ALL && !user_mode |-> ##257 op_done)
		else $error("whole invalidate length wrong");
	priv_trap_a: assert property (
		take && priv && user_mode |=> op_done && exc_program)
		else $error("no program fault in user mode");
	data_fault_a: assert property (
		exc_data_storage || exc_data_tlb |-> op_done
		&& op_reg == `ICM_XO_LINE_INVAL)
		else $error("data fault from wrong op");
	dac_kind_a: assert property (
		dac_load |-> lookup_valid && dac_addr == lookup_addr
		&& (op_reg == `ICM_XO_LINE_INVAL
		|| op_reg == `ICM_XO_LINE_TOUCH))
		else $error("compare event wrong");
	fill_line_a: assert property (
		fill_req |-> op_reg == `ICM_XO_LINE_TOUCH
		&& fill_addr == {lookup_addr[31:5], 5'h00})
		else $error("fill address wrong");
	fill_hold_a: assert property (
		fill_req && !fill_done |=> fill_req)
		else $error("fill dropped early");
	readout_upd_a: assert property (
		!$stable(icache_debug_readout) |-> op_done
		&& op_reg == `ICM_XO_DEBUG_READ)
		else $error("readout changed outside a read");
	tag_zero_a: assert property (
		!$stable(icache_debug_readout) && read_select_bit
		|-> icache_debug_readout[9:5] == 5'h00
		&& icache_debug_readout[3:1] == 3'h0)
		else $error("reserved readout bits set");
	cover property (take && xo == `ICM_XO_DEBUG_READ);
	cover property (fill_req && fill_done);
	cover property (exc_data_tlb);
	cover property (exc_program);
endmodule
`default_nettype wire

/* icm_far_model.sv */
// Purpose: Model of translation, cache arrays and memory for icm_ops.
// Assumes: Answers are combinational on the registered lookup address.
// Notes:   cfg bits: 1:0 way hit, 3:2 valid, 4 tlb miss, 5 zone block,
//          6 cacheable, 7 recency, 8 slow fill.
`timescale 1ns/1ps
`default_nettype none

module icm_far_model
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic [31:0] lookup_addr,
	input  wire logic [7:0]  arr_index,
	input  wire logic [2:0]  arr_word,
	input  wire logic        fill_req,
	input  wire logic [8:0]  cfg,
	output logic             tlb_hit,
	output logic             zone_no_access,
	output logic             attr_cacheable,
	output logic [43:0]      arr_tags,
	output logic [1:0]       arr_valid,
	output logic             arr_lru,
	output logic [63:0]      arr_words,
	output logic             fill_done
);
	wire [21:0] tag = lookup_addr[31:10];
	logic [2:0] wait_cnt;
	// A missing way shows the inverted tag, so no stale match can occur.
	assign arr_tags = {cfg[1] ? tag : ~tag, cfg[0] ? tag : ~tag};
	assign arr_valid = cfg[3:2];
	assign arr_lru = cfg[7];
	assign tlb_hit = !cfg[4];
	assign zone_no_access = cfg[5];
	assign attr_cacheable = cfg[6];
	assign arr_words = {16'hbbbb, arr_index, 5'h00, arr_word,
		16'haaaa, arr_index, 5'h00, arr_word};
	// Memory ends a fill at once or five cycles late.
	always_ff @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
		begin
			wait_cnt <= 3'h0;
			fill_done <= 1'b0;
		end
		else
		begin
			fill_done <= fill_req && !fill_done
				&& wait_cnt == (cfg[8] ? 3'h5 : 3'h0);
			wait_cnt <= fill_req ? wait_cnt + 3'h1 : 3'h0;
		end
endmodule
`default_nettype wire

/* icm_ops_tb.sv */
// Purpose: Self-checking bench for icm_ops.
// Assumes: 40 MHz clock; inputs change 1 ns after the rising edge.
// Notes:   Each op waits for op_done under a bounded loop.
`timescale 1ns/1ps
`default_nettype none
`include "icm_defs.vh"

module icm_ops_tb;
	logic        sys_clk, rst_b, issue_valid, user_mode, data_reloc;
	logic        way_select_bit, read_select_bit, tlb_hit, zone_no_access;
	logic        attr_cacheable, arr_lru, fill_done, issue_ready, dac;
	logic        idx_bad;
	logic        lookup_valid, fill_req, fill_way, dac_load, op_done;
	logic        exc_data_storage, exc_data_tlb, exc_program, rsvd_seen;
	logic [31:0] instr_word, base_data, index_data, lookup_addr, fill_addr;
	logic [31:0] dac_addr, icache_debug_readout, ea, fa;
	logic [63:0] arr_words;
	logic [43:0] arr_tags;
	logic [8:0]  cfg;
	logic [7:0]  arr_index;
	logic [2:0]  arr_word, ex;
	logic [1:0]  arr_valid, arr_inval_way, inv;
	int          fails, comparisons, n, nfill, ninv, i;
	// Line invalidate cases: cfg, user, ways cleared, faults.
	logic [14:0] li_t [6] = '{{9'h00d, 6'h08}, {9'h00e, 6'h10},
		{9'h00c, 6'h00}, {9'h01d, 6'h01}, {9'h02d, 6'h22},
		{9'h02d, 6'h08}};
	// Touch cases: cfg, user, fill expected.
	logic [10:0] tt_t [6] = '{{9'h04c, 2'h1}, {9'h1cc, 2'h1},
		{9'h04d, 2'h0}, {9'h00c, 2'h0}, {9'h05c, 2'h0}, {9'h06c, 2'h2}};

	icm_ops u_dut (.*);
	icm_far_model u_far (.*);
	//////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// A hung op must still reach the verdict.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		$display("[ERR] %0t run did not finish", $time);
		results;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Offers one op, then records what the ports show until op_done.
	task automatic run(input logic [9:0] xo, input logic [4:0] bf,
		input logic usr, input logic [8:0] c, input logic [4:0] rsv);
		int k;
		cfg = c;
		user_mode = usr;
		instr_word = {`ICM_OPC_PRIMARY, rsv, bf, 5'h03, xo, rsv[0]};
		ea = (bf == 5'h00 ? 32'h0 : base_data) + index_data;
		issue_valid = 1'b1;
		@(posedge sys_clk);
		#1 issue_valid = 1'b0;
		{n, nfill, ninv, inv, idx_bad} = '0;
		// The lookup cycle is already under way, so catch its strobe now.
		dac = dac_load;
		for (k = 0; k < 400 && op_done !== 1'b1; k++)
		begin
			@(posedge sys_clk);
			#1 n++;
			inv = inv | arr_inval_way;
			idx_bad |= (arr_inval_way === 2'b11)
				&& (arr_index !== ninv[7:0]);
			ninv += (arr_inval_way === 2'b11);
			nfill += (fill_req === 1'b1);
			dac = dac | dac_load;
			if (fill_req === 1'b1)
				fa = fill_addr;
		end
		if (op_done !== 1'b1)
		begin
			fails++;
			$display("[ERR] %0t op never completed", $time);
		end
		ex = {exc_program, exc_data_storage, exc_data_tlb};
		@(posedge sys_clk);
		#1;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_b, issue_valid, user_mode} = '0;
		{way_select_bit, read_select_bit} = '0;
		{instr_word, cfg, fails, comparisons} = '0;
		data_reloc = 1'b1;
		base_data = 32'h0001_2348;
		index_data = 32'h0000_0a7c;
		repeat (12) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		for (i = 0; i < 4; i++)
		begin
			way_select_bit = i[0];
			run(`ICM_XO_DEBUG_READ, i[1] ? 5'h04 : 5'h00, 1'b0, 9'h00c,
				5'h00);
			chk(n, 2);
			fa = {i[0] ? 16'hbbbb : 16'haaaa, ea[12:5], 5'h00, ea[4:2]};
			chk(icache_debug_readout, fa);
		end
		read_select_bit = 1'b1;
		way_select_bit = 1'b1;
		run(`ICM_XO_DEBUG_READ, 5'h04, 1'b0, 9'h08a, 5'h00);
		fa = {ea[31:10], 5'h00, 1'b1, 3'h0, 1'b1};
		chk(icache_debug_readout, fa);
		way_select_bit = 1'b0;
		run(`ICM_XO_DEBUG_READ, 5'h04, 1'b0, 9'h008, 5'h00);
		chk(icache_debug_readout, {~ea[31:10], 10'h000});
		$display("test debug read done");
		for (i = 0; i < 6; i++)
		begin
			run(`ICM_XO_LINE_INVAL, 5'h04, li_t[i][5], li_t[i][14:6], 5'h00);
			chk(inv, li_t[i][4:3]);
			chk(ex, li_t[i][2:0]);
			chk(dac, 1'b1);
		end
		$display("test line invalidate done");
		for (i = 0; i < 6; i++)
		begin
			run(`ICM_XO_LINE_TOUCH, 5'h04, tt_t[i][1], tt_t[i][10:2], 5'h00);
			chk(nfill != 0, tt_t[i][0]);
			chk(ex, 3'h0);
			chk(dac, 1'b1);
			if (tt_t[i][0])
			begin
				chk(fa, {ea[31:5], 5'h00});
				chk(fill_way, tt_t[i][9]);
			end
		end
		$display("test touch done");
		run(`ICM_XO_INVAL_ALL, 5'h07, 1'b0, 9'h03c, 5'h00);
		chk(n, 256);
		chk(ninv, 256);
		chk(idx_bad, 1'b0);
		chk({ex, dac}, 4'h0);
		run(`ICM_XO_INVAL_ALL, 5'h07, 1'b1, 9'h00c, 5'h00);
		chk({n[3:0], ex, ninv[0]}, 8'h08);
		run(`ICM_XO_DEBUG_READ, 5'h04, 1'b1, 9'h00c, 5'h00);
		chk(ex, 3'h4);
		$display("test privilege done");
		run(`ICM_XO_DEBUG_READ, 5'h04, 1'b0, 9'h00c, 5'h15);
		chk({n[3:0], ex, rsvd_seen}, 8'h21);
		$display("test reserved bits done");
		results;
	end
endmodule

bind icm_ops icm_ops_monitor u_mon (.*);
`default_nettype wire
